// file: core/adc_sampler.sv
// Converter timing and offset correction for the system monitor.
// Assumes start is only pulsed while no conversion is running.
`timescale 1ns/1ps
`default_nettype none
module adc_sampler
  import sysmon_pkg::*;
#(
  parameter int CONVERSION_TRIGGER_CYC = CONVERSION_TRIGGER_CYCLES
) (
  input wire logic clk,
  input wire logic srst,
  conversion_trigger_if.conversion_trigger cv
);
  localparam int CW = $clog2(CONVERSION_TRIGGER_CYC + 1);
  logic [CW-1:0] cnt_q;  // Cycles spent in the current conversion.
  logic busy_q;          // Conversion running.
  logic [7:0] raw_q;     // Level caught at launch.
  logic [7:0] off_q;     // Offset caught at launch.
  logic apply_q;         // Correction caught at launch.
  logic done_q;
  logic [7:0] result_q;
  logic signed [9:0] diff; // Raw minus signed offset.

  // Subtract the signed offset and clamp into the 8-bit range.
  assign diff = $signed({2'b00, raw_q}) - $signed({{2{off_q[7]}}, off_q});

  // One conversion takes the fixed conversion time, then reports once.
  always_ff @(posedge clk) begin
    if (srst) begin
      busy_q <= 1'b0;
      cnt_q <= '0;
      raw_q <= 8'h00;
      off_q <= 8'h00;
      apply_q <= 1'b0;
      done_q <= 1'b0;
      result_q <= 8'h00;
    end else begin
      done_q <= 1'b0;
      if (cv.start && !busy_q) begin
        busy_q <= 1'b1;
        cnt_q <= '0;
        raw_q <= cv.raw;
        off_q <= cv.offset;
        apply_q <= cv.apply;
      end else if (busy_q) begin
        if (cnt_q == CW'(CONVERSION_TRIGGER_CYC - 1)) begin
          busy_q <= 1'b0;
          done_q <= 1'b1;
          if (!apply_q) begin
            result_q <= raw_q;
          end else if (diff < 0) begin
            result_q <= 8'h00;
          end else if (diff > 10'sd255) begin
            result_q <= 8'hff;
          end else begin
            result_q <= diff[7:0];
          end
        end else begin
          cnt_q <= cnt_q + 1'b1;
        end
      end
    end
  end
  assign cv.done = done_q;
  assign cv.result = result_q;

  // Without correction the raw level passes untouched; the cycle counter marks the last cycle.
  property p_no_corr;
    @(posedge clk) disable iff (srst)
      (busy_q && !apply_q && cnt_q == CW'(CONVERSION_TRIGGER_CYC - 1)) |=> (done_q && result_q == raw_q);
  endproperty
  a_no_corr: assert property (p_no_corr) else $error("uncorrected result differs from raw");
endmodule // adc_sampler
`default_nettype wire

// file: core/conversion_trigger_if.sv
// Link between the sequencer and the converter timing model.
// Assumes both ends run on the one system clock.
`timescale 1ns/1ps
`default_nettype none
interface conversion_trigger_if;
  logic start;        // One-cycle launch pulse.
  logic [7:0] raw;    // Uncorrected level for this conversion.
  logic [7:0] offset; // Signed correction value.
  logic apply;        // Correction is applied when high.
  logic done;         // One-cycle completion pulse.
  logic [7:0] result; // Corrected result, valid with done.
  modport ctrl(output start, raw, offset, apply, input done, result);
  modport conversion_trigger(input start, raw, offset, apply, output done, result);
endinterface
`default_nettype wire

// file: core/sysmon_pkg.sv
// Constants, field layout and types of the system monitor converter control.
// Assumes a 40 MHz clock and byte registers reached over an AXI4-Lite slave.
// How it works
// - One 8-bit converter measures internal levels.
// - One measurement at a time; start when ready.
// - Completion pulses the matching event line.
// - Offset setup resets to 0x01.
// - Offset mode stores result as calibrated offset.
// - Source bit picks offset; enable bit gates correction.
// - Mode write then trigger bit starts conversion.
// - Mode field encodes six measurement kinds.
// - Averaging of 2 to 16, not offset.
// - Each kind has own result register, but both battery kinds share one and averaged runs all land in one.
// - Delayed battery waits 5 plus 4*field ms.
// - Abort ends delay and converts at once.
// - Task bits are write-one strobes only.
// - Pin select picks window control pin.
// - Set strobe opens the droop window.
// - Regulator mode snapshot kept for battery.
// - Status shows busy, droop and recovery.
// - Offsets are signed two's complement bytes.
// - Clear strobe closes window, converts minimum.
// - Set/clear strobes start/stop recovery counter.
package sysmon_pkg;
  // Register indices; byte address is four times the index.
  localparam logic [7:0] IDX_TASK = 8'h90;
  localparam logic [7:0] IDX_CFG = 8'h91;
  localparam logic [7:0] IDX_DELAY = 8'h92;
  localparam logic [7:0] IDX_OFSCFG = 8'h93;
  localparam logic [7:0] IDX_SET = 8'h94;
  localparam logic [7:0] IDX_CLR = 8'h95;
  localparam logic [7:0] IDX_BATT = 8'h96;
  localparam logic [7:0] IDX_TEMP = 8'h97;
  localparam logic [7:0] IDX_DROOP = 8'h98;
  localparam logic [7:0] IDX_LEVEL = 8'h99;
  localparam logic [7:0] IDX_RECOV = 8'h9a;
  localparam logic [7:0] IDX_AVG = 8'h9b;
  localparam logic [7:0] IDX_BOOST = 8'h9c;
  localparam logic [7:0] IDX_STATUS = 8'h9d;
  localparam logic [7:0] IDX_FACTORY = 8'h9e;
  localparam logic [7:0] IDX_CALIB = 8'h9f;
  // Field positions.
  localparam int MODE_LSB = 0;
  localparam int AVG_LSB = 3;
  localparam int PINSEL_LSB = 6;
  localparam int TASK_CONVERSION_TRIGGER_BIT = 0;
  localparam int TASK_ABORT_BIT = 1;
  localparam int OFS_EN_BIT = 0;
  localparam int OFS_SEL_BIT = 1;
  localparam int CTRL_DROOP_BIT = 0;
  localparam int CTRL_RECOV_BIT = 1;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_DROOP_BIT = 1;
  localparam int STAT_RECOV_BIT = 2;
  // Reset values.
  localparam logic [7:0] REG_RST = 8'h00;
  localparam logic [1:0] OFSCFG_RST = 2'h1;
  // Window pin select codes and the largest averaging code.
  localparam logic [1:0] PIN_ZERO = 2'h1;
  localparam logic [1:0] PIN_ONE = 2'h2;
  localparam logic [2:0] AVG_MAX = 3'h4;
  // Timing.
  localparam int CLK_PERIOD_NS = 25;
  localparam int T_CONVERSION_TRIGGER_NS = 100000;
  localparam int CONVERSION_TRIGGER_CYCLES = (T_CONVERSION_TRIGGER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int T_MS_NS = 1000000;
  localparam int MS_CYCLES = T_MS_NS / CLK_PERIOD_NS;
  localparam int DELAY_BASE_MS = 5;
  localparam int DELAY_STEP_MS = 4;
  // Bus answers.
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Measurement modes.
  typedef enum logic [2:0] {
    instant_battery_mode = 3'h0,
    delayed_battery_mode = 3'h1,
    die_heat_mode = 3'h2,
    output_sag_mode = 3'h3,
    regulated_output_voltage = 3'h4,
    offset_measure_mode = 3'h5
  } mode_e;
  // Sequencer states.
  typedef enum logic [2:0] {
    st_idle = 3'b001,
    st_delay = 3'b010,
    st_conversion_trigger = 3'b100
  } state_e;
endpackage

// file: core/system_monitor_adc_control.sv
// Sequencer, register file and AXI4-Lite slave of the system monitor converter.
// Assumes synchronous level inputs and a master with one access of each kind open.
`timescale 1ns/1ps
`default_nettype none
module system_monitor_adc_control
  import sysmon_pkg::*;
#(
  parameter int ADDR_W = 12,
  parameter int MS_CYC = MS_CYCLES,
  parameter int CONVERSION_TRIGGER_CYC = CONVERSION_TRIGGER_CYCLES
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic [7:0] battery_level,
  input wire logic [7:0] die_heat_level,
  input wire logic [7:0] output_level,
  input wire logic [7:0] offset_level,
  input wire logic [1:0] regulator_mode,
  input wire logic general_pin_zero,
  input wire logic general_pin_one,
  output logic [5:0] done_event
);
  localparam int MSW = $clog2(MS_CYC);

  // Bus state.
  logic [ADDR_W-1:0] waddr_q; // Captured write address.
  logic [7:0] wdata_q;        // Captured low data byte.
  logic wstrb0_q;             // Low byte lane enabled.
  logic aw_got_q;             // Write address held.
  logic w_got_q;              // Write data held.
  logic wr_en;                // Mapped write with low lane, one cycle.
  logic [7:0] rd_val;         // Read data for the presented address.
  // Registers.
  logic [7:0] cfg_q;
  logic [7:0] delay_q;
  logic [1:0] ofscfg_q;
  logic [7:0] factory_q;
  logic task_conversion_trigger_q, task_abort_q; // One-cycle task strobes.
  logic droop_open_q;              // Window opened by strobe.
  logic recov_run_q;               // Recovery counter running.
  logic [7:0] batt_q, temp_q, droop_q, regulated_output_voltage_q, recov_q, avg_q, calib_q;
  logic [1:0] boost_q;
  // Sequencer.
  state_e st_q;
  mode_e cur_mode_q;
  logic start_q;            // Launch pulse to the converter.
  logic [10:0] dly_cnt_q;   // Whole milliseconds waited.
  logic [10:0] dly_target;  // Milliseconds to wait.
  logic [MSW-1:0] ms_cnt_q; // Millisecond divider.
  logic ms_tick;
  logic [3:0] n_q;          // Samples taken so far.
  logic [2:0] sh_q;         // Averaging shift for this run.
  logic [11:0] acc_q;
  logic [11:0] acc_next;
  logic last;               // Current sample ends the run.
  logic win, win_q;         // Droop window level now and last cycle.
  logic droop_go;           // Window just closed.
  logic [7:0] min_q;        // Lowest output level inside the window.
  mode_e req_mode;
  logic start_req, req_ok;
  conversion_trigger_if cv();

  // Only indices 0x90 to 0x9f answer; the rest are unmapped.
  function automatic logic mapped(input logic [ADDR_W-1:0] a);
    return (a[ADDR_W-1:10] == '0) && (a[9:6] == IDX_TASK[7:4]);
  endfunction

  // True for a write that lands on the given register.
  function automatic logic wr_hit(input logic [7:0] idx);
    return wr_en && (waddr_q[9:2] == idx);
  endfunction

  wire aw_fire = awvalid & awready;
  wire w_fire = wvalid & wready;
  wire ar_fire = arvalid & arready;
  wire wr_do = aw_got_q & w_got_q & ~bvalid;
  assign wr_en = wr_do & wstrb0_q & mapped(waddr_q);

  // Write address channel: hold one address until the write is done.
  always_ff @(posedge clk) begin
    if (srst) begin
      aw_got_q <= 1'b0;
      awready <= 1'b0;
      waddr_q <= '0;
    end else begin
      if (aw_fire) begin
        aw_got_q <= 1'b1;
        waddr_q <= awaddr;
      end else if (wr_do) begin
        aw_got_q <= 1'b0;
      end
      awready <= ~(aw_fire | (aw_got_q & ~wr_do));
    end
  end

  // Write data channel: the low byte carries the register value.
  always_ff @(posedge clk) begin
    if (srst) begin
      w_got_q <= 1'b0;
      wready <= 1'b0;
      wdata_q <= 8'h00;
      wstrb0_q <= 1'b0;
    end else begin
      if (w_fire) begin
        w_got_q <= 1'b1;
        wdata_q <= wdata[7:0];
        wstrb0_q <= wstrb[0];
      end else if (wr_do) begin
        w_got_q <= 1'b0;
      end
      wready <= ~(w_fire | (w_got_q & ~wr_do));
    end
  end

  // Write response: unmapped addresses answer with a slave error.
  always_ff @(posedge clk) begin
    if (srst) begin
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
    end else if (wr_do) begin
      bvalid <= 1'b1;
      bresp <= mapped(waddr_q) ? RESP_OKAY : RESP_SLVERR;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  // Read value mux; task and reserved bits read as zero.
  always_comb begin
    case (araddr[9:2])
      IDX_CFG: rd_val = cfg_q;
      IDX_DELAY: rd_val = delay_q;
      IDX_OFSCFG: rd_val = {6'h00, ofscfg_q};
      IDX_SET, IDX_CLR: rd_val = {6'h00, recov_run_q, droop_open_q};
      IDX_BATT: rd_val = batt_q;
      IDX_TEMP: rd_val = temp_q;
      IDX_DROOP: rd_val = droop_q;
      IDX_LEVEL: rd_val = regulated_output_voltage_q;
      IDX_RECOV: rd_val = recov_q;
      IDX_AVG: rd_val = avg_q;
      IDX_BOOST: rd_val = {6'h00, boost_q};
      IDX_STATUS: rd_val = {5'h00, recov_run_q, win_q, st_q != st_idle};
      IDX_FACTORY: rd_val = factory_q;
      IDX_CALIB: rd_val = calib_q;
      default: rd_val = 8'h00;
    endcase
  end

  // Read channel: data answer one cycle after the address is taken.
  always_ff @(posedge clk) begin
    if (srst) begin
      arready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= RESP_OKAY;
    end else begin
      arready <= ~ar_fire & ~(rvalid & ~rready);
      if (ar_fire) begin
        rvalid <= 1'b1;
        rdata <= mapped(araddr) ? {24'h00_0000, rd_val} : 32'h0000_0000;
        rresp <= mapped(araddr) ? RESP_OKAY : RESP_SLVERR;
      end else if (rready) begin
        rvalid <= 1'b0;
      end
    end
  end

  // Read/write setup registers.
  always_ff @(posedge clk) begin
    if (srst) begin
      cfg_q <= REG_RST;
      delay_q <= REG_RST;
      ofscfg_q <= OFSCFG_RST;
      factory_q <= REG_RST;
    end else begin
      if (wr_hit(IDX_CFG)) cfg_q <= wdata_q;
      if (wr_hit(IDX_DELAY)) delay_q <= wdata_q;
      if (wr_hit(IDX_OFSCFG)) ofscfg_q <= wdata_q[1:0];
      if (wr_hit(IDX_FACTORY)) factory_q <= wdata_q;
    end
  end

  // Task bits act only when written as one and never hold a value.
  always_ff @(posedge clk) begin
    if (srst) begin
      task_conversion_trigger_q <= 1'b0;
      task_abort_q <= 1'b0;
    end else begin
      task_conversion_trigger_q <= wr_hit(IDX_TASK) & wdata_q[TASK_CONVERSION_TRIGGER_BIT];
      task_abort_q <= wr_hit(IDX_TASK) & wdata_q[TASK_ABORT_BIT];
    end
  end

  // Droop window strobe: set register opens it, clear register closes it.
  always_ff @(posedge clk) begin
    if (srst) begin
      droop_open_q <= 1'b0;
    end else if (wr_hit(IDX_SET) && wdata_q[CTRL_DROOP_BIT]) begin
      droop_open_q <= 1'b1;
    end else if (wr_hit(IDX_CLR) && wdata_q[CTRL_DROOP_BIT]) begin
      droop_open_q <= 1'b0;
    end
  end

  // A selected general pin also holds the window open while high.
  always_comb begin
    case (cfg_q[PINSEL_LSB +: 2])
      PIN_ZERO: win = droop_open_q | general_pin_zero;
      PIN_ONE: win = droop_open_q | general_pin_one;
      default: win = droop_open_q;
    endcase
  end
  assign droop_go = win_q & ~win;

  // Track the lowest output level seen while the window is open.
  always_ff @(posedge clk) begin
    if (srst) begin
      win_q <= 1'b0;
      min_q <= 8'hff;
    end else begin
      win_q <= win;
      if (win && !win_q) begin
        min_q <= output_level;
      end else if (win && output_level < min_q) begin
        min_q <= output_level;
      end
    end
  end

  // Millisecond divider, restarted when a delay begins.
  assign ms_tick = (ms_cnt_q == MSW'(MS_CYC - 1));
  always_ff @(posedge clk) begin
    if (srst || st_q != st_delay || ms_tick) begin
      ms_cnt_q <= '0;
    end else begin
      ms_cnt_q <= ms_cnt_q + 1'b1;
    end
  end

  // Recovery time counter in milliseconds, saturating at full scale.
  // It shares the delay divider, so it only advances while a delayed run waits.
  always_ff @(posedge clk) begin
    if (srst) begin
      recov_run_q <= 1'b0;
      recov_q <= 8'h00;
    end else if (wr_hit(IDX_SET) && wdata_q[CTRL_RECOV_BIT]) begin
      recov_run_q <= 1'b1;
      recov_q <= 8'h00;
    end else if (wr_hit(IDX_CLR) && wdata_q[CTRL_RECOV_BIT]) begin
      recov_run_q <= 1'b0;
    end else if (recov_run_q && ms_tick && recov_q != 8'hff) begin
      recov_q <= recov_q + 8'h01;
    end
  end

  // Request decode; the closing droop window takes priority over a task.
  assign start_req = task_conversion_trigger_q | droop_go;
  assign req_mode = droop_go ? output_sag_mode : mode_e'(cfg_q[MODE_LSB +: 3]);
  assign req_ok = (req_mode <= offset_measure_mode);
  assign dly_target = 11'(DELAY_BASE_MS) + 11'(DELAY_STEP_MS) * {3'h0, delay_q};
  assign acc_next = acc_q + {4'h0, cv.result};
  assign last = (n_q == 4'((1 << sh_q) - 1));

  // Sequencer: idle, optional delay, then one or more conversions.
  always_ff @(posedge clk) begin
    if (srst) begin
      st_q <= st_idle;
      cur_mode_q <= instant_battery_mode;
      start_q <= 1'b0;
      dly_cnt_q <= 11'h000;
      n_q <= 4'h0;
      sh_q <= 3'h0;
      acc_q <= 12'h000;
    end else begin
      start_q <= 1'b0;
      case (st_q)
        st_idle: begin
          if (start_req && req_ok) begin
            cur_mode_q <= req_mode;
            n_q <= 4'h0;
            acc_q <= 12'h000;
            // Offset runs and unknown codes take a single sample.
            if (req_mode == offset_measure_mode || cfg_q[AVG_LSB +: 3] > AVG_MAX) begin
              sh_q <= 3'h0;
            end else begin
              sh_q <= cfg_q[AVG_LSB +: 3];
            end
            if (req_mode == delayed_battery_mode) begin
              st_q <= st_delay;
              dly_cnt_q <= 11'h000;
            end else begin
              st_q <= st_conversion_trigger;
              start_q <= 1'b1;
            end
          end
        end
        st_delay: begin
          if (task_abort_q || (ms_tick && dly_cnt_q == dly_target - 11'h001)) begin
            st_q <= st_conversion_trigger;
            start_q <= 1'b1;
          end else if (ms_tick) begin
            dly_cnt_q <= dly_cnt_q + 11'h001;
          end
        end
        st_conversion_trigger: begin
          // New tasks are not looked at here, so a busy run is undisturbed.
          if (cv.done) begin
            acc_q <= acc_next;
            if (last) begin
              st_q <= st_idle;
            end else begin
              n_q <= n_q + 4'h1;
              start_q <= 1'b1;
            end
          end
        end
        default: st_q <= st_idle;
      endcase
    end
  end

  // Converter inputs: level chosen by mode and the selected offset.
  always_comb begin
    case (cur_mode_q)
      die_heat_mode: cv.raw = die_heat_level;
      output_sag_mode: cv.raw = min_q;
      regulated_output_voltage: cv.raw = output_level;
      offset_measure_mode: cv.raw = offset_level;
      default: cv.raw = battery_level;
    endcase
  end
  assign cv.start = start_q;
  assign cv.offset = ofscfg_q[OFS_SEL_BIT] ? calib_q : factory_q;
  assign cv.apply = ofscfg_q[OFS_EN_BIT] && cur_mode_q != offset_measure_mode;

  adc_sampler #(.CONVERSION_TRIGGER_CYC(CONVERSION_TRIGGER_CYC)) u_sampler (
    .clk(clk),
    .srst(srst),
    .cv(cv)
  );

  // Results land only when the whole run finishes, with the event pulse.
  always_ff @(posedge clk) begin
    if (srst) begin
      {batt_q, temp_q, droop_q, regulated_output_voltage_q, avg_q, calib_q} <= '0;
      boost_q <= 2'h0;
      done_event <= 6'h00;
    end else begin
      done_event <= 6'h00;
      if (st_q == st_conversion_trigger && cv.done && last) begin
        done_event <= 6'(1 << cur_mode_q);
        if (cur_mode_q == instant_battery_mode || cur_mode_q == delayed_battery_mode) begin
          boost_q <= regulator_mode;
        end
        if (sh_q != 3'h0) begin
          avg_q <= 8'(acc_next >> sh_q);
        end else begin
          case (cur_mode_q)
            die_heat_mode: temp_q <= cv.result;
            output_sag_mode: droop_q <= cv.result;
            regulated_output_voltage: regulated_output_voltage_q <= cv.result;
            offset_measure_mode: calib_q <= cv.result;
            default: batt_q <= cv.result;
          endcase
        end
      end
    end
  end

  // Checks.
  property p_ofs_reset;
    @(posedge clk) srst |=> ofscfg_q == OFSCFG_RST;
  endproperty
  a_ofs_reset: assert property (p_ofs_reset) else $error("offset setup reset wrong");

  property p_busy_ignore;
    @(posedge clk) disable iff (srst) (st_q != st_idle && task_conversion_trigger_q) |=> $stable(cur_mode_q);
  endproperty
  a_busy_ignore: assert property (p_busy_ignore) else $error("task disturbed a run");

  property p_event;
    @(posedge clk) disable iff (srst)
      (st_q == st_conversion_trigger && cv.done && last) |=> (done_event != 6'h00) ##1 (done_event == 6'h00);
  endproperty
  a_event: assert property (p_event) else $error("completion event missing");

  property p_abort;
    @(posedge clk) disable iff (srst) (st_q == st_delay && task_abort_q) |=> st_q == st_conversion_trigger && start_q;
  endproperty
  a_abort: assert property (p_abort) else $error("abort did not launch");

  property p_delay_hold;
    @(posedge clk) disable iff (srst)
      (st_q == st_delay && !task_abort_q && !(ms_tick && dly_cnt_q == dly_target - 11'h001))
      |=> st_q == st_delay;
  endproperty
  a_delay_hold: assert property (p_delay_hold) else $error("delay ended early");

  property p_result_hold;
    @(posedge clk) disable iff (srst) (st_q == st_conversion_trigger && !cv.done) |=> $stable(batt_q) && $stable(avg_q);
  endproperty
  a_result_hold: assert property (p_result_hold) else $error("result moved mid run");

  property p_droop_go;
    @(posedge clk) disable iff (srst)
      (droop_go && st_q == st_idle) |=> st_q == st_conversion_trigger && cur_mode_q == output_sag_mode;
  endproperty
  a_droop_go: assert property (p_droop_go) else $error("window close did not convert");

  property p_task_pulse;
    @(posedge clk) disable iff (srst) task_conversion_trigger_q |=> !task_conversion_trigger_q || $past(wr_en);
  endproperty
  a_task_pulse: assert property (p_task_pulse) else $error("task strobe held");

  property p_status;
    @(posedge clk) disable iff (srst)
      (ar_fire && mapped(araddr) && araddr[9:2] == IDX_STATUS) |=> rdata[0] == ($past(st_q) != st_idle);
  endproperty
  a_status: assert property (p_status) else $error("status busy bit wrong");

  c_delayed: cover property (@(posedge clk) disable iff (srst) st_q == st_delay ##1 st_q == st_conversion_trigger);
  c_abort: cover property (@(posedge clk) disable iff (srst) st_q == st_delay && task_abort_q);
  c_avg: cover property (@(posedge clk) disable iff (srst) cv.done && last && sh_q == 3'h4);
  c_droop: cover property (@(posedge clk) disable iff (srst) droop_go && st_q == st_idle);
endmodule // system_monitor_adc_control
`default_nettype wire

// file: tb/system_monitor_adc_control_tb_top.sv
// Self-checking bench for the system monitor converter control.
// Assumes the sysmon_pkg package and the design sources are compiled first.
`timescale 1ns/1ps
`default_nettype none
module system_monitor_adc_control_tb_top import sysmon_pkg::*;;
  // Bus, level and event signals of the block under test.
  logic clk, srst, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, general_pin_zero, general_pin_one;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, regulator_mode, br;
  logic [7:0] battery_level, die_heat_level, output_level, offset_level, d;
  logic [5:0] done_event;
  int fails, total_checks, n;
  // Short counts keep the delayed runs brief.
  system_monitor_adc_control #(.MS_CYC(20), .CONVERSION_TRIGGER_CYC(10)) i_system_monitor_adc_control (
    .clk, .srst, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp,
    .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
    .battery_level, .die_heat_level, .output_level, .offset_level, .regulator_mode,
    .general_pin_zero, .general_pin_one, .done_event);
  // Clock of 25 ns period.
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // Counts a comparison and reports a mismatch.
  task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
    total_checks++;
    if (g !== e) begin
      fails++;
      $display("ERROR %0t: %s got %h exp %h", $time, m, g, e);
    end
  endtask
  // Writes one byte register; address and data are offered together.
  task automatic wr(input logic [7:0] i, input logic [7:0] v);
    @(posedge clk);
    awaddr <= {2'h0, i, 2'h0};
    wdata <= {24'h0, v};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    br = bresp;
    bready <= 1'b0;
  endtask
  // Reads one word; the data byte lands in d and the response in the returned code.
  task automatic rd(input logic [7:0] i, output logic [1:0] r);
    @(posedge clk);
    araddr <= {2'h0, i, 2'h0};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    d = rdata[7:0];
    r = rresp;
    rready <= 1'b0;
  endtask
  // Reads a register and compares its byte.
  task automatic rc(input logic [7:0] i, input logic [7:0] e);
    logic [1:0] r;
    rd(i, r);
    chk(d, e, "reg");
  endtask
  // Waits for a completion pulse, returning the cycles spent.
  task automatic wt(input int b, output int c);
    c = 0;
    do begin
      @(posedge clk);
      c++;
    end while (done_event[b] !== 1'b1 && c < 3000);
    chk(done_event, 32'h1 << b, "event");
  endtask
  // Reset values, unmapped access and a corrected single shot.
  task automatic t_basic();
    logic [1:0] r;
    rc(IDX_OFSCFG, 8'h01);
    rd(8'h50, r);
    chk(r, RESP_SLVERR, "resp");
    wr(8'h50, 8'h00);
    chk(br, RESP_SLVERR, "bresp");
    wr(IDX_FACTORY, 8'h03);
    chk(br, RESP_OKAY, "bresp");
    wr(IDX_CFG, 8'h02);
    wr(IDX_TASK, 8'h01);
    rc(IDX_STATUS, 8'h01);
    wt(2, n);
    rc(IDX_TEMP, 8'h3d);
    $display("basic done");
  endtask
  // Offset recalibration, source select and correction off.
  task automatic t_offset();
    wr(IDX_CFG, 8'h05);
    wr(IDX_TASK, 8'h01);
    wt(5, n);
    rc(IDX_CALIB, 8'h07);
    wr(IDX_OFSCFG, 8'h03);
    wr(IDX_CFG, 8'h02);
    wr(IDX_TASK, 8'h01);
    wt(2, n);
    rc(IDX_TEMP, 8'h39);
    wr(IDX_OFSCFG, 8'h02);
    wr(IDX_TASK, 8'h03);
    wt(2, n);
    rc(IDX_TEMP, 8'h40);
    $display("offset done");
  endtask
  // Averaging by 2, delayed battery and abort.
  task automatic t_avg_delay();
    wr(IDX_CFG, 8'h0c);
    wr(IDX_TASK, 8'h01);
    wt(4, n);
    rc(IDX_AVG, 8'h22);
    rc(IDX_LEVEL, 8'h00);
    wr(IDX_SET, 8'h02);
    wr(IDX_DELAY, 8'h01);
    wr(IDX_CFG, 8'h01);
    wr(IDX_TASK, 8'h01);
    wt(1, n);
    chk(n inside {[180:210]}, 1, "delay");
    rc(IDX_BATT, 8'h55);
    rc(IDX_BOOST, 8'h02);
    rc(IDX_STATUS, 8'h04);
    wr(IDX_CLR, 8'h02);
    rc(IDX_RECOV, 8'h09);
    wr(IDX_DELAY, 8'hff);
    wr(IDX_TASK, 8'h01);
    wr(IDX_TASK, 8'h01);
    wr(IDX_TASK, 8'h02);
    wt(1, n);
    chk(n < 40, 1, "abort");
    $display("averaged_result and delay done");
  endtask
  // Droop window opened and closed by the strobe registers, then held open by general pin zero.
  task automatic t_droop();
    wr(IDX_CFG, 8'h03);
    wr(IDX_SET, 8'h01);
    rc(IDX_STATUS, 8'h02);
    output_level <= 8'h18;
    wr(IDX_SET, 8'h00);
    output_level <= 8'h28;
    wr(IDX_CLR, 8'h01);
    wt(3, n);
    rc(IDX_DROOP, 8'h18);
    wr(IDX_CFG, 8'h43);
    general_pin_zero <= 1'b1;
    output_level <= 8'h11;
    rc(IDX_STATUS, 8'h02);
    general_pin_zero <= 1'b0;
    wt(3, n);
    rc(IDX_DROOP, 8'h11);
    $display("droop done");
  endtask
  // Prints the counts and the verdict, then ends the run.
  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // Watchdog well beyond the expected run length.
  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    close_out();
  end
  // Main sequence: reset for ten cycles, then the tests.
  initial begin
    {srst, awvalid, wvalid, bready, arvalid, rready} = 6'h20;
    {general_pin_zero, general_pin_one, awaddr, araddr, wdata} = '0;
    wstrb = 4'hf;
    regulator_mode = 2'h2;
    {battery_level, die_heat_level, output_level, offset_level} = 32'h55402207;
    repeat (10) @(posedge clk);
    srst <= 1'b0;
    t_basic();
    t_offset();
    output_level <= 8'h22;
    t_avg_delay();
    output_level <= 8'h30;
    t_droop();
    close_out();
  end
endmodule // system_monitor_adc_control_tb_top
`default_nettype wire
